// ---- hw/ddrc_pkg.sv ----
package ddrc_pkg;

    // Own clock and the command clock made from it by division.
    localparam int MCLK_PS = 20000;
    localparam int CK_HALF_MCLK = 2;
    localparam int TCK_PS = MCLK_PS * CK_HALF_MCLK * 2;

    // Fixed burst length in data beats and write latency in command clock cycles.
    localparam int BL = 8;
    localparam int CWL = 5;

    // Minimum times as printed, in picoseconds, and cycle floors.
    localparam int RTP_PS = 7500;
    localparam int RTP_FLOOR = 4;
    localparam int WTR_PS = 7500;
    localparam int WTR_FLOOR = 4;
    localparam int WR_PS = 15000;
    localparam int MRD_FLOOR = 4;
    localparam int MOD_PS = 15000;
    localparam int MOD_FLOOR = 12;
    localparam int CCD_FLOOR = 4;
    localparam int MPRR_FLOOR = 1;
    // Speed grade values, plain defaults.
    localparam int RCD_PS = 15000;
    localparam int RP_PS = 15000;
    localparam int RC_PS = 52500;

    function automatic int ck_ceil(input int ps, input int floor_ck);
        int n;
        n = (ps + TCK_PS - 1) / TCK_PS;
        ck_ceil = (n > floor_ck) ? n : floor_ck;
    endfunction

    localparam logic [5:0] RTP_CK = 6'(ck_ceil(RTP_PS, RTP_FLOOR));
    localparam logic [5:0] WTR_CK = 6'(ck_ceil(WTR_PS, WTR_FLOOR));
    localparam logic [5:0] WR_CK = 6'(ck_ceil(WR_PS, 1));
    localparam logic [5:0] MRD_CK = 6'(MRD_FLOOR);
    localparam logic [5:0] MOD_CK = 6'(ck_ceil(MOD_PS, MOD_FLOOR));
    localparam logic [5:0] CCD_CK = 6'(CCD_FLOOR);
    localparam logic [5:0] MPRR_CK = 6'(MPRR_FLOOR);
    localparam logic [5:0] RCD_CK = 6'(ck_ceil(RCD_PS, 1));
    localparam logic [5:0] RP_CK = 6'(ck_ceil(RP_PS, 1));
    localparam logic [5:0] RC_CK = 6'(ck_ceil(RC_PS, 1));
    localparam logic [5:0] DAL_CK = 6'(ck_ceil(WR_PS, 1) + ck_ceil(RP_PS, 1));
    // Gaps counted from a write command through the end of its data; RD_ACT_CK from a read.
    localparam logic [5:0] WDATA_CK = 6'(CWL + BL / 2);
    localparam logic [5:0] WR_RD_CK = 6'(CWL + BL / 2 + ck_ceil(WTR_PS, WTR_FLOOR));
    localparam logic [5:0] WR_PRE_CK = 6'(CWL + BL / 2 + ck_ceil(WR_PS, 1));
    localparam logic [5:0] WR_ACT_CK = 6'(CWL + BL / 2 + ck_ceil(WR_PS, 1) + ck_ceil(RP_PS, 1));
    localparam logic [5:0] RD_ACT_CK = 6'(ck_ceil(RTP_PS, RTP_FLOOR) + ck_ceil(RP_PS, 1));
    // A single frame counter drives the strobe, so a write waits until the last frame ends.
    localparam logic [5:0] WR_WR_CK = 6'(CWL + 1 + BL / 2);

    // Write strobe frame, in half command clock cycles, counting the issue edge as 1.
    localparam logic [5:0] WSTB_LEAD = 6'(2 * CWL - 1);
    localparam logic [5:0] WSTB_BURST = 6'(2 * CWL + 1);
    localparam logic [5:0] WSTB_TAIL = 6'(2 * CWL + 1 + BL);
    localparam logic [5:0] WSTB_END = 6'(2 * CWL + 2 + BL);

    localparam logic [1:0] DIV_LAST = 2'(CK_HALF_MCLK - 1);

    // Chip select, row strobe, column strobe, write enable; all active low.
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_ACT = 4'h3;
    localparam logic [3:0] PIN_RD = 4'h5;
    localparam logic [3:0] PIN_WR = 4'h4;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_REF = 4'h1;
    localparam logic [3:0] PIN_MRS = 4'h0;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
    } ddrc_cmd_t;

    typedef struct packed {
        logic valid;
        ddrc_cmd_t cmd;
        logic [2:0] bank;
        logic [13:0] addr;
        logic auto_pre;
        logic mpr_exit;
    } ddrc_req_t;

    typedef struct packed {
        logic [3:0] ctl_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } ddrc_pins_t;

    typedef struct packed {
        logic [1:0] cnt;
        logic ck;
        logic rise;
        logic fall;
    } ddrc_div_t;

    typedef struct packed {
        logic [7:0][5:0] act_cnt;
        logic [7:0][5:0] col_cnt;
        logic [7:0][5:0] pre_cnt;
        logic [5:0] ccd;
        logic [5:0] wtr;
        logic [5:0] ww;
        logic [5:0] mrd;
        logic [5:0] mod;
        logic [5:0] mprr;
        logic [5:0] wstb;
        logic dqs;
        logic dqs_oe;
        logic accept;
        ddrc_pins_t pins;
    } ddrc_state_t;

endpackage

// ---- hw/ddrc_ck_div.sv ----
`timescale 1ns/1ps
module ddrc_ck_div (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    output logic ck_out,
    output logic rise_out,
    output logic fall_out
);
    ddrc_pkg::ddrc_div_t st_reg;
    ddrc_pkg::ddrc_div_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rise = 1'b0;
        st_next.fall = 1'b0;
        if (st_reg.cnt == ddrc_pkg::DIV_LAST) begin
            st_next.cnt = 2'h0;
            st_next.ck = ~st_reg.ck;
            st_next.rise = ~st_reg.ck;
            st_next.fall = st_reg.ck;
        end else begin
            st_next.cnt = st_reg.cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ck_out = st_reg.ck;
    assign rise_out = st_reg.rise;
    assign fall_out = st_reg.fall;
endmodule

// ---- hw/ddrc_cmd_sched.sv ----
// Notes on behaviour
// - Read to precharge waits four cycles, 7.5ns.
// - Write data end to read waits.
// - Write recovery 15ns; auto-precharge adds precharge time.
// - Four cycles between mode register sets.
// - Mode set update delay before other commands.
// - Column commands at least four cycles apart.
// - One cycle recovery after special register exit.
// - Activate to column delay per bank.
// - Activate to activate row cycle per bank.
// - Write strobe lead and tail driven here.
`timescale 1ns/1ps
module ddrc_cmd_sched (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input ddrc_pkg::ddrc_req_t req_in,
    output logic accept_out,
    output logic ck_out,
    output ddrc_pkg::ddrc_pins_t pins_out,
    output logic dqs_out,
    output logic dqs_oe_out
);
    ddrc_pkg::ddrc_state_t st_reg;
    ddrc_pkg::ddrc_state_t st_next;
    logic tick_rise;
    logic tick_fall;
    logic allowed;

    ddrc_ck_div u_div (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .ck_out(ck_out),
        .rise_out(tick_rise),
        .fall_out(tick_fall)
    );

    function automatic logic [5:0] dec6(input logic [5:0] x);
        dec6 = (x == 6'h00) ? 6'h00 : x - 6'h01;
    endfunction

    // A counter holds the cycles still to wait after the next edge, so a
    // gap of n cycles loads n-1 and never shortens a longer wait in flight.
    function automatic logic [5:0] hold(input logic [5:0] cur, input logic [5:0] n);
        logic [5:0] v;
        v = dec6(n);
        hold = (v > cur) ? v : cur;
    endfunction

    function automatic logic [3:0] ctl_of(input ddrc_pkg::ddrc_cmd_t c);
        unique case (c)
            ddrc_pkg::CMD_NOP: ctl_of = ddrc_pkg::PIN_NOP;
            ddrc_pkg::CMD_ACT: ctl_of = ddrc_pkg::PIN_ACT;
            ddrc_pkg::CMD_RD: ctl_of = ddrc_pkg::PIN_RD;
            ddrc_pkg::CMD_WR: ctl_of = ddrc_pkg::PIN_WR;
            ddrc_pkg::CMD_PRE: ctl_of = ddrc_pkg::PIN_PRE;
            ddrc_pkg::CMD_REF: ctl_of = ddrc_pkg::PIN_REF;
            ddrc_pkg::CMD_MRS: ctl_of = ddrc_pkg::PIN_MRS;
            default: ctl_of = ddrc_pkg::PIN_NOP;
        endcase
    endfunction

    // Holding commands until every counter that guards them has expired.
    // bank and global counters
    always_comb begin
        logic idle_mode;
        logic [2:0] b;
        idle_mode = (st_reg.mod == 6'h00) && (st_reg.mprr == 6'h00);
        b = req_in.bank;
        unique case (req_in.cmd)
            ddrc_pkg::CMD_ACT: allowed = idle_mode && (st_reg.act_cnt[b] == 6'h00);
            ddrc_pkg::CMD_RD: allowed = idle_mode && (st_reg.col_cnt[b] == 6'h00)
                && (st_reg.ccd == 6'h00) && (st_reg.wtr == 6'h00);
            ddrc_pkg::CMD_WR: allowed = idle_mode && (st_reg.col_cnt[b] == 6'h00)
                && (st_reg.ccd == 6'h00) && (st_reg.ww == 6'h00);
            ddrc_pkg::CMD_PRE: allowed = idle_mode && (st_reg.pre_cnt[b] == 6'h00);
            ddrc_pkg::CMD_REF: allowed = idle_mode && (st_reg.act_cnt == '0);
            ddrc_pkg::CMD_MRS: allowed = (st_reg.mrd == 6'h00) && (st_reg.mprr == 6'h00);
            default: allowed = 1'b0;
        endcase
    end

    always_comb begin
        logic [2:0] b;
        logic [5:0] h;
        b = req_in.bank;
        h = 6'h00;
        st_next = st_reg;
        st_next.accept = 1'b0;
        // Write strobe walks its frame on both command clock edges.
        if (tick_rise || tick_fall) begin
            if (st_reg.wstb != 6'h00) begin
                h = (st_reg.wstb == ddrc_pkg::WSTB_END) ? 6'h00 : st_reg.wstb + 6'h01;
            end
            st_next.wstb = h;
            st_next.dqs_oe = (h >= ddrc_pkg::WSTB_LEAD) && (h <= ddrc_pkg::WSTB_TAIL);
            st_next.dqs = (h >= ddrc_pkg::WSTB_BURST) && (h < ddrc_pkg::WSTB_TAIL) && h[0];
        end
        // Commands change on the falling edge so the device samples mid-cycle.
        if (tick_fall) begin
            for (int i = 0; i < 8; i++) begin
                st_next.act_cnt[i] = dec6(st_reg.act_cnt[i]);
                st_next.col_cnt[i] = dec6(st_reg.col_cnt[i]);
                st_next.pre_cnt[i] = dec6(st_reg.pre_cnt[i]);
            end
            st_next.ccd = dec6(st_reg.ccd);
            st_next.wtr = dec6(st_reg.wtr);
            st_next.ww = dec6(st_reg.ww);
            st_next.mrd = dec6(st_reg.mrd);
            st_next.mod = dec6(st_reg.mod);
            st_next.mprr = dec6(st_reg.mprr);
            st_next.pins.ctl_n = ddrc_pkg::PIN_NOP;
            if (req_in.valid && allowed) begin
                st_next.accept = 1'b1;
                st_next.pins.ctl_n = ctl_of(req_in.cmd);
                st_next.pins.ba = b;
                st_next.pins.addr = req_in.addr;
                unique case (req_in.cmd)
                    ddrc_pkg::CMD_ACT: begin
                        st_next.col_cnt[b] = hold(st_next.col_cnt[b], ddrc_pkg::RCD_CK);
                        st_next.act_cnt[b] = hold(st_next.act_cnt[b], ddrc_pkg::RC_CK);
                    end
                    ddrc_pkg::CMD_RD: begin
                        st_next.pins.addr[10] = req_in.auto_pre;
                        st_next.ccd = hold(st_next.ccd, ddrc_pkg::CCD_CK);
                        st_next.pre_cnt[b] = hold(st_next.pre_cnt[b], ddrc_pkg::RTP_CK);
                        if (req_in.auto_pre) begin
                            st_next.act_cnt[b] = hold(st_next.act_cnt[b], ddrc_pkg::RD_ACT_CK);
                        end
                    end
                    ddrc_pkg::CMD_WR: begin
                        st_next.pins.addr[10] = req_in.auto_pre;
                        st_next.ccd = hold(st_next.ccd, ddrc_pkg::CCD_CK);
                        st_next.ww = hold(st_next.ww, ddrc_pkg::WR_WR_CK);
                        st_next.wtr = hold(st_next.wtr, ddrc_pkg::WR_RD_CK);
                        st_next.pre_cnt[b] = hold(st_next.pre_cnt[b], ddrc_pkg::WR_PRE_CK);
                        if (req_in.auto_pre) begin
                            st_next.act_cnt[b] = hold(st_next.act_cnt[b], ddrc_pkg::WR_ACT_CK);
                        end
                        st_next.wstb = 6'h01;
                    end
                    ddrc_pkg::CMD_PRE: begin
                        st_next.pins.addr[10] = 1'b0;
                        st_next.act_cnt[b] = hold(st_next.act_cnt[b], ddrc_pkg::RP_CK);
                    end
                    ddrc_pkg::CMD_MRS: begin
                        st_next.mrd = hold(st_next.mrd, ddrc_pkg::MRD_CK);
                        st_next.mod = hold(st_next.mod, ddrc_pkg::MOD_CK);
                        if (req_in.mpr_exit) begin
                            st_next.mprr = hold(st_next.mprr, ddrc_pkg::MPRR_CK);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
            st_reg.pins.ctl_n <= ddrc_pkg::PIN_NOP;
        end else begin
            st_reg <= st_next;
        end
    end

    assign accept_out = st_reg.accept;
    assign pins_out = st_reg.pins;
    assign dqs_out = st_reg.dqs;
    assign dqs_oe_out = st_reg.dqs_oe;

    // Helper counters: command clock cycles since the last command of a kind.
    logic [5:0] s_col, s_mrs, s_wr, s_rd, s_act, s_mprx;
    logic [2:0] b_wr, b_rd, b_act;
    logic is_col, is_mrs, is_any;

    assign is_any = accept_out;
    assign is_col = accept_out && ((pins_out.ctl_n == ddrc_pkg::PIN_RD)
        || (pins_out.ctl_n == ddrc_pkg::PIN_WR));
    assign is_mrs = accept_out && (pins_out.ctl_n == ddrc_pkg::PIN_MRS);

    function automatic logic [5:0] sat_inc(input logic [5:0] x);
        sat_inc = (x == 6'h3f) ? x : x + 6'h01;
    endfunction

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {s_col, s_mrs, s_wr, s_rd, s_act, s_mprx} <= {6{6'h3f}};
            {b_wr, b_rd, b_act} <= '0;
        end else if (tick_fall) begin
            {s_col, s_mrs, s_wr} <= {sat_inc(s_col), sat_inc(s_mrs), sat_inc(s_wr)};
            {s_rd, s_act, s_mprx} <= {sat_inc(s_rd), sat_inc(s_act), sat_inc(s_mprx)};
        end else if (is_any) begin
            if (is_col) s_col <= 6'h00;
            if (is_mrs) s_mrs <= 6'h00;
            if (is_mrs && req_in.mpr_exit) s_mprx <= 6'h00;
            if (pins_out.ctl_n == ddrc_pkg::PIN_WR) {s_wr, b_wr} <= {6'h00, pins_out.ba};
            if (pins_out.ctl_n == ddrc_pkg::PIN_RD) {s_rd, b_rd} <= {6'h00, pins_out.ba};
            if (pins_out.ctl_n == ddrc_pkg::PIN_ACT) {s_act, b_act} <= {6'h00, pins_out.ba};
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_lead;
        (dqs_oe_out && !dqs_out) [*4];
    endsequence
    sequence s_first_high;
        (dqs_oe_out && dqs_out) [*2];
    endsequence

    a_col_spacing: assert property (is_col |-> s_col >= ddrc_pkg::CCD_CK)
        else $error("column commands too close");
    a_mrs_spacing: assert property (is_mrs |-> s_mrs >= ddrc_pkg::MRD_CK)
        else $error("mode sets too close");
    a_mode_update: assert property (is_any && !is_mrs |-> s_mrs >= ddrc_pkg::MOD_CK)
        else $error("command inside mode update delay");
    a_wr_to_rd: assert property (is_any && pins_out.ctl_n == ddrc_pkg::PIN_RD
        |-> s_wr >= ddrc_pkg::WR_RD_CK)
        else $error("read too soon after write");
    a_rd_to_pre: assert property (is_any && pins_out.ctl_n == ddrc_pkg::PIN_PRE
        && pins_out.ba == b_rd |-> s_rd >= ddrc_pkg::RTP_CK)
        else $error("precharge too soon after read");
    a_wr_recovery: assert property (is_any && pins_out.ctl_n == ddrc_pkg::PIN_PRE
        && pins_out.ba == b_wr |-> s_wr >= ddrc_pkg::WR_PRE_CK)
        else $error("precharge inside write recovery");
    a_act_to_col: assert property (is_col && pins_out.ba == b_act
        |-> s_act >= ddrc_pkg::RCD_CK)
        else $error("column command before activate delay");
    a_row_cycle: assert property (is_any && pins_out.ctl_n == ddrc_pkg::PIN_ACT
        && pins_out.ba == b_act |-> s_act >= ddrc_pkg::RC_CK)
        else $error("activates too close on one bank");
    a_mpr_recover: assert property (is_any && !is_mrs |-> s_mprx >= ddrc_pkg::MPRR_CK)
        else $error("command inside special register recovery");
    a_wstb_frame: assert property ($rose(dqs_oe_out) |-> s_lead ##1 s_first_high)
        else $error("write strobe lead malformed");
endmodule

// ---- dv/ddrc_dev_model.sv ----
`timescale 1ns/1ps
module ddrc_dev_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ck_in,
    input ddrc_pkg::ddrc_pins_t pins_in,
    output int viol_out,
    output logic rd_oe_out
);
    localparam int TCK = ddrc_pkg::TCK_PS;
    localparam int WEND = ddrc_pkg::CWL + ddrc_pkg::BL / 2;
    localparam int RL = 6;
    int cyc = 0;
    int rd_at = -99;
    int t_col = -99;
    int t_wany = -99;
    int t_mrs = -99;
    int mrs_gap = 0;
    int t_act[8] = '{default: -99};
    int t_rd[8] = '{default: -99};
    int t_wr[8] = '{default: -99};
    int t_pre[8] = '{default: -99};
    logic [7:0] ap_rd = 8'h00;
    logic [7:0] ap_wr = 8'h00;
    logic ck_d = 1'b0;
    logic [2:0] b;

    function automatic int rup(input int ps, input int fl);
        return ((ps + TCK - 1) / TCK > fl) ? (ps + TCK - 1) / TCK : fl;
    endfunction

    // Every gap is counted in command clock rises, so it is immune to the mclk phase.
    task automatic need(input int since, input int gap);
        if (cyc - since < gap)
            viol_out++;
    endtask

    assign rd_oe_out = (cyc >= rd_at + RL - 1) && (cyc < rd_at + RL + ddrc_pkg::BL / 2);

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            viol_out = 0;
        end else if (ck_in && !ck_d) begin
            cyc++;
            b = pins_in.ba;
            if (pins_in.ctl_n != ddrc_pkg::PIN_MRS && pins_in.ctl_n != ddrc_pkg::PIN_NOP)
                need(t_mrs, mrs_gap);
            case (pins_in.ctl_n)
                ddrc_pkg::PIN_ACT: begin
                    need(t_act[b], rup(ddrc_pkg::RC_PS, 1));
                    need(t_pre[b], rup(ddrc_pkg::RP_PS, 1));
                    need(t_wr[b], ap_wr[b] ? WEND + rup(15000, 1) + rup(ddrc_pkg::RP_PS, 1) : 0);
                    need(t_rd[b], ap_rd[b] ? rup(7500, 4) + rup(ddrc_pkg::RP_PS, 1) : 0);
                    t_act[b] = cyc;
                end
                ddrc_pkg::PIN_RD, ddrc_pkg::PIN_WR: begin
                    need(t_act[b], rup(ddrc_pkg::RCD_PS, 1));
                    need(t_col, 4);
                    t_col = cyc;
                    if (pins_in.ctl_n == ddrc_pkg::PIN_RD) begin
                        need(t_wany, WEND + rup(7500, 4));
                        t_rd[b] = cyc;
                        ap_rd[b] = pins_in.addr[10];
                        rd_at = cyc;
                    end else begin
                        t_wr[b] = cyc;
                        t_wany = cyc;
                        ap_wr[b] = pins_in.addr[10];
                    end
                end
                ddrc_pkg::PIN_PRE: begin
                    need(t_rd[b], rup(7500, 4));
                    need(t_wr[b], WEND + rup(15000, 1));
                    t_pre[b] = cyc;
                end
                ddrc_pkg::PIN_REF: begin
                    for (int i = 0; i < 8; i++)
                        need(t_act[i], rup(ddrc_pkg::RC_PS, 1));
                end
                ddrc_pkg::PIN_MRS: begin
                    need(t_mrs, 4);
                    t_mrs = cyc;
                    mrs_gap = (b == 3'h3 && !pins_in.addr[2]) ? 1 : rup(15000, 12);
                end
                default: ;
            endcase
        end
        ck_d = ck_in;
    end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam int TCK = ddrc_pkg::TCK_PS;
    localparam int MCK = ddrc_pkg::MCLK_PS;
    localparam int WEND = ddrc_pkg::CWL + ddrc_pkg::BL / 2;

    function automatic int rup(input int ps, input int fl);
        return ((ps + TCK - 1) / TCK > fl) ? (ps + TCK - 1) / TCK : fl;
    endfunction

    localparam int MOD = rup(15000, 12);
    localparam int RTP = rup(7500, 4);
    localparam int WRP = WEND + rup(15000, 1);
    localparam int WTR = WEND + rup(7500, 4);
    localparam int RCD = rup(ddrc_pkg::RCD_PS, 1);
    localparam int RP = rup(ddrc_pkg::RP_PS, 1);
    // Strobe lead and tail minimums, rounded up to whole mclk cycles.
    localparam int LEAD_MIN = (9 * TCK + 10 * MCK - 1) / (10 * MCK);
    localparam int TAIL_MIN = (3 * TCK + 10 * MCK - 1) / (10 * MCK);
    // Active-low chip select, row, column and write enable, indexed by command.
    localparam logic [3:0] PIN_CODE [7] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0};

    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    ddrc_pkg::ddrc_req_t req_in = '0;
    logic accept_out, ck_out, dqs_out, dqs_oe_out;
    ddrc_pkg::ddrc_pins_t pins_out;
    int viol, miscompares = 0, checked = 0, now = 0, t_last = 0;
    int n_wr = 0, n_frm = 0, oe_len = 0, rises = 0, lead = 0, tail = 0, acc = 0;
    logic dqs_d = 1'b0;
    logic [7:0] open_b = 8'h01;
    logic [13:0] ad;
    logic [2:0] bk;
    logic [1:0] c;

    ddrc_cmd_sched dut (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .req_in(req_in),
        .accept_out(accept_out),
        .ck_out(ck_out),
        .pins_out(pins_out),
        .dqs_out(dqs_out),
        .dqs_oe_out(dqs_oe_out)
    );

    ddrc_dev_model dev (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .ck_in(ck_out),
        .pins_in(pins_out),
        .viol_out(viol),
        .rd_oe_out()
    );

    always #10 mclk_in = ~mclk_in;

    always @(posedge mclk_in) now <= now + 1;

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pins(input ddrc_pkg::ddrc_pins_t got, input ddrc_pkg::ddrc_pins_t exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Presents one command, waits for its acceptance and checks pins and spacing.
    task automatic sd(input ddrc_pkg::ddrc_cmd_t cmd, input logic [2:0] bank,
                      input logic [13:0] addr, input logic ap, input logic mpr, input int gap);
        ddrc_pkg::ddrc_pins_t exp;
        int n;
        exp = '{PIN_CODE[cmd], bank, addr};
        if (cmd == ddrc_pkg::CMD_RD || cmd == ddrc_pkg::CMD_WR)
            exp.addr[10] = ap;
        n = 0;
        @(posedge mclk_in);
        req_in <= '{1'b1, cmd, bank, addr, ap, mpr};
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (accept_out !== 1'b1 && n < 400);
        if (accept_out !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        cmp_pins(pins_out, exp);
        if (gap >= 0)
            cmp_val(now - t_last, gap * TCK / MCK);
        t_last = now;
        if (cmd == ddrc_pkg::CMD_WR)
            n_wr++;
        @(posedge mclk_in);
        req_in.valid <= 1'b0;
    endtask

    // Each write strobe frame is measured while the enable stands.
    always @(posedge mclk_in) begin
        if (dqs_oe_out === 1'b1) begin
            oe_len++;
            if (dqs_out === 1'b1 && dqs_d !== 1'b1)
                rises++;
            if (rises == 0)
                lead++;
            tail = (dqs_out === 1'b0) ? tail + 1 : 0;
        end else if (oe_len > 0) begin
            cmp_val(rises, ddrc_pkg::BL / 2);
            cmp_val(lead >= LEAD_MIN, 1);
            cmp_val(tail >= TAIL_MIN, 1);
            n_frm++;
            oe_len = 0;
            rises = 0;
            lead = 0;
            tail = 0;
        end
        dqs_d = dqs_out;
    end

    initial begin
        void'($urandom(32'h97c5));
        repeat (8) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        cmp_pins(pins_out, '{4'h7, 3'h0, 14'h0});
        cmp_val({accept_out, ck_out, dqs_oe_out}, 32'h0);
        @(posedge mclk_in);
        req_in.valid <= 1'b1;
        repeat (40) begin
            @(posedge mclk_in);
            #1;
            if (accept_out !== 1'b0)
                acc++;
        end
        cmp_val(acc, 32'h0);
        $display("test reset_and_idle done");
        ad = 14'($urandom);
        sd(ddrc_pkg::CMD_MRS, 3'h1, ad, 1'b0, 1'b0, -1);
        sd(ddrc_pkg::CMD_MRS, 3'h0, ad, 1'b0, 1'b0, 4);
        sd(ddrc_pkg::CMD_ACT, 3'h0, ad, 1'b0, 1'b0, MOD);
        sd(ddrc_pkg::CMD_PRE, 3'h0, 14'h0, 1'b0, 1'b0, -1);
        sd(ddrc_pkg::CMD_MRS, 3'h3, 14'h0, 1'b0, 1'b1, -1);
        sd(ddrc_pkg::CMD_ACT, 3'h0, ad, 1'b0, 1'b0, MOD);
        sd(ddrc_pkg::CMD_RD, 3'h0, ad, 1'b0, 1'b0, RCD);
        sd(ddrc_pkg::CMD_RD, 3'h0, ~ad, 1'b0, 1'b0, 4);
        sd(ddrc_pkg::CMD_PRE, 3'h0, 14'h0, 1'b0, 1'b0, RTP);
        sd(ddrc_pkg::CMD_ACT, 3'h0, ad, 1'b0, 1'b0, RP);
        sd(ddrc_pkg::CMD_WR, 3'h0, ad, 1'b0, 1'b0, RCD);
        sd(ddrc_pkg::CMD_PRE, 3'h0, 14'h0, 1'b0, 1'b0, WRP);
        sd(ddrc_pkg::CMD_ACT, 3'h0, ad, 1'b0, 1'b0, RP);
        sd(ddrc_pkg::CMD_WR, 3'h0, ~ad, 1'b1, 1'b0, RCD);
        sd(ddrc_pkg::CMD_ACT, 3'h0, ad, 1'b0, 1'b0, WRP + RP);
        sd(ddrc_pkg::CMD_WR, 3'h0, ad, 1'b0, 1'b0, RCD);
        sd(ddrc_pkg::CMD_RD, 3'h0, ad, 1'b0, 1'b0, WTR);
        cmp_val(viol, 32'h0);
        $display("test directed_spacing done");
        repeat (60) begin
            bk = 3'($urandom_range(7));
            ad = 14'($urandom);
            c = 2'($urandom_range(3));
            if (!open_b[bk]) begin
                sd(ddrc_pkg::CMD_ACT, bk, ad, 1'b0, 1'b0, -1);
                open_b[bk] = 1'b1;
            end else if (c == 2'h0) begin
                sd(ddrc_pkg::CMD_PRE, bk, 14'h0, 1'b0, 1'b0, -1);
                open_b[bk] = 1'b0;
            end else begin
                sd(c[0] ? ddrc_pkg::CMD_RD : ddrc_pkg::CMD_WR, bk, ad, ad[11], 1'b0, -1);
                open_b[bk] = open_b[bk] & ~ad[11];
            end
        end
        for (int i = 0; i < 8; i++)
            if (open_b[i])
                sd(ddrc_pkg::CMD_PRE, 3'(i), 14'h0, 1'b0, 1'b0, -1);
        sd(ddrc_pkg::CMD_REF, 3'h0, 14'h0, 1'b0, 1'b0, -1);
        repeat (100) @(posedge mclk_in);
        cmp_val(n_frm, n_wr);
        cmp_val(viol, 32'h0);
        $display("test random_traffic done");
        stop_test();
    end
endmodule
